// ---- timer_defs.vh ----
// Register offsets, field positions and reset values for the dual timer/counter.
// Included by the timer design files; definitions only.
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH
`define ADDR_TIMER_CONTROL_STATUS 8'h88
`define ADDR_TIMER_MODE_CONFIG 8'h89
`define ADDR_TIMER0_COUNT_LOW 8'h8A
`define ADDR_TIMER1_COUNT_LOW 8'h8B
`define ADDR_TIMER0_COUNT_HIGH 8'h8C
`define ADDR_TIMER1_COUNT_HIGH 8'h8D
`define RST_TIMER_CONTROL_STATUS 8'h00
`define RST_TIMER_MODE_CONFIG 8'h00
`define RST_TIMER_COUNT 8'h00
`define READ_UNMAPPED 8'h00
`define TCS_TIMER1_OVERFLOW 7
`define TCS_TIMER1_RUN 6
`define TCS_TIMER0_OVERFLOW 5
`define TCS_TIMER0_RUN 4
`define TCS_EXT_IRQ1_FLAG 3
`define TCS_EXT_IRQ1_TYPE 2
`define TCS_EXT_IRQ0_FLAG 1
`define TCS_EXT_IRQ0_TYPE 0
`define TMC_TIMER1_GATE 7
`define TMC_TIMER1_COUNTER_SEL 6
`define TMC_TIMER1_MODE_HI 5
`define TMC_TIMER1_MODE_LO 4
`define TMC_TIMER0_GATE 3
`define TMC_TIMER0_COUNTER_SEL 2
`define TMC_TIMER0_MODE_HI 1
`define TMC_TIMER0_MODE_LO 0
`define MODE_PRESCALED13 2'h0
`define MODE_FULL16 2'h1
`define MODE_AUTO_RELOAD 2'h2
`define MODE_SPLIT 2'h3
`define PRESCALE_MASK 8'h1F
`define BYTE_ALL_ONES 8'hFF
`endif

// ---- timer_pin_sync.v ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clock; only the second stage is read outside.
`timescale 1ns/1ps
module timer_pin_sync #(
  parameter WIDTH = 4
) (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire [WIDTH-1:0] pin_async,
  output reg [WIDTH-1:0] pin_sync_q
);
  reg [WIDTH-1:0] meta_q;

  // Resets high so idle-high pins do not look like falling edges after reset.
  always @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      meta_q <= {WIDTH{1'b1}};
      pin_sync_q <= {WIDTH{1'b1}};
    end
    else if (clk_en)
    begin
      meta_q <= pin_async;
      pin_sync_q <= meta_q;
    end
endmodule

// ---- ext_irq_detect.v ----
// One external interrupt request flag with edge or level triggering.
// Assumes pin_sync is already synchronised and the ack and write strobes are single-cycle.
`timescale 1ns/1ps
`include "timer_defs.vh"
module ext_irq_detect (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire pin_sync,
  input wire type_edge,
  input wire ack,
  input wire flag_wr,
  input wire flag_wdata,
  output reg flag_q
);
  reg pin_prev_q;
  reg flag_d;
  wire set_event;

  // Falling edge when type is 1, low level when type is 0.
  assign set_event = type_edge ? (pin_prev_q & ~pin_sync) : ~pin_sync;
  always @*
  begin
    flag_d = flag_q;
    if (ack)
      flag_d = 1'b0;
    if (flag_wr)
      flag_d = flag_wdata;
    // A new request beats a clear in the same cycle.
    if (set_event)
      flag_d = 1'b1;
  end

  always @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      pin_prev_q <= 1'b1;
      flag_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_prev_q <= pin_sync;
      flag_q <= flag_d;
    end
endmodule

// ---- dual_timer_counter.v ----
// Two timer/counters with external interrupt 0/1 flags, reached over the SFR bus.
// Assumes single-cycle sfr_wr/sfr_rd strobes from the core on the same clock, and
// one-cycle service acknowledges from the interrupt controller.
`timescale 1ns/1ps
`include "timer_defs.vh"
module dual_timer_counter (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata_q,
  input wire external_irq0_input,
  input wire external_irq1_input,
  input wire count0_input,
  input wire count1_input,
  input wire timer0_irq_ack,
  input wire timer1_irq_ack,
  input wire ext_irq0_ack,
  input wire ext_irq1_ack,
  output wire timer0_overflow_flag,
  output wire timer1_overflow_flag,
  output wire ext_irq0_flag,
  output wire ext_irq1_flag,
  output reg timer1_overflow_tick_q
);
  reg [7:0] tmc_q;
  reg timer0_run_bit_q;
  reg timer1_run_bit_q;
  reg timer0_overflow_flag_q;
  reg timer1_overflow_flag_q;
  reg ext_irq0_type_bit_q;
  reg ext_irq1_type_bit_q;
  reg [7:0] timer0_count_low_q;
  reg [7:0] timer0_count_high_q;
  reg [7:0] timer1_count_low_q;
  reg [7:0] timer1_count_high_q;
  reg [1:0] count_prev_q;
  wire [3:0] pins_sync;
  wire irq0_pin;
  wire irq1_pin;
  wire [1:0] count_pin;
  wire [1:0] count_fall;
  wire [1:0] timer0_mode;
  wire [1:0] timer1_mode;
  wire split_mode;
  wire timer0_enable;
  wire timer1_enable;
  wire high0_enable;
  wire [16:0] step0;
  wire [16:0] step1;
  wire [8:0] high0_next;
  wire wr_tcs;
  wire wr_tmc;
  wire wr_tl0;
  wire wr_th0;
  wire wr_tl1;
  wire wr_th1;
  wire timer0_ovf;
  wire timer1_ovf_own;
  wire timer1_flag_set;
  reg timer0_overflow_flag_d;
  reg timer1_overflow_flag_d;
  reg [7:0] read_mux;

  // Advances one timer by one count. Result is {overflow, high, low}.
  function [16:0] timer_step;
    input [1:0] mode;
    input [7:0] high;
    input [7:0] low;
    reg [5:0] low5;
    reg [8:0] high9;
    reg [8:0] low9;
    begin
      low5 = {1'b0, low[4:0]} + 6'h01;
      high9 = {1'b0, high} + 9'h001;
      low9 = {1'b0, low} + 9'h001;
      timer_step = {1'b0, high, low};
      case (mode)
        `MODE_PRESCALED13:
        begin
          // Top three low bits are left as they are and never carry.
          if (low5[5])
            timer_step = {high9[8], high9[7:0], low[7:5], 5'h00};
          else
            timer_step = {1'b0, high, low[7:5], low5[4:0]};
        end
        `MODE_FULL16:
        begin
          if (low9[8])
            timer_step = {high9[8], high9[7:0], 8'h00};
          else
            timer_step = {1'b0, high, low9[7:0]};
        end
        `MODE_AUTO_RELOAD:
        begin
          if (low9[8])
            timer_step = {1'b1, high, high};
          else
            timer_step = {1'b0, high, low9[7:0]};
        end
        default:
          timer_step = {1'b0, high, low};
      endcase
    end
  endfunction

  timer_pin_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_async({count1_input, count0_input, external_irq1_input, external_irq0_input}),
    .pin_sync_q(pins_sync)
  );

  assign irq0_pin = pins_sync[0];
  assign irq1_pin = pins_sync[1];
  assign count_pin = pins_sync[3:2];
  assign count_fall = count_prev_q & ~count_pin;

  assign wr_tcs = sfr_wr && (sfr_addr == `ADDR_TIMER_CONTROL_STATUS);
  assign wr_tmc = sfr_wr && (sfr_addr == `ADDR_TIMER_MODE_CONFIG);
  assign wr_tl0 = sfr_wr && (sfr_addr == `ADDR_TIMER0_COUNT_LOW);
  assign wr_th0 = sfr_wr && (sfr_addr == `ADDR_TIMER0_COUNT_HIGH);
  assign wr_tl1 = sfr_wr && (sfr_addr == `ADDR_TIMER1_COUNT_LOW);
  assign wr_th1 = sfr_wr && (sfr_addr == `ADDR_TIMER1_COUNT_HIGH);

  assign timer0_mode = tmc_q[`TMC_TIMER0_MODE_HI:`TMC_TIMER0_MODE_LO];
  assign timer1_mode = tmc_q[`TMC_TIMER1_MODE_HI:`TMC_TIMER1_MODE_LO];
  assign split_mode = (timer0_mode == `MODE_SPLIT);

  // Gate bits live in the mode register, run bits in the control register.
  assign timer0_enable = timer0_run_bit_q
    && (!tmc_q[`TMC_TIMER0_GATE] || irq0_pin)
    && (!tmc_q[`TMC_TIMER0_COUNTER_SEL] || count_fall[0]);
  assign timer1_enable = timer1_run_bit_q
    && (!tmc_q[`TMC_TIMER1_GATE] || irq1_pin)
    && (!tmc_q[`TMC_TIMER1_COUNTER_SEL] || count_fall[1]);
  // With timer 0 split, timer 1 is started and stopped by its own mode alone.
  wire timer1_go;
  assign timer1_go = split_mode ? (timer1_mode != `MODE_SPLIT) : timer1_enable;
  // The split high half counts machine cycles under timer 1 run only.
  assign high0_enable = split_mode && timer1_run_bit_q;

  assign step0 = timer_step(timer0_mode, timer0_count_high_q, timer0_count_low_q);
  assign step1 = timer_step(timer1_mode, timer1_count_high_q, timer1_count_low_q);
  assign high0_next = {1'b0, timer0_count_high_q} + 9'h001;

  assign timer0_ovf = timer0_enable && (split_mode ? (timer0_count_low_q == `BYTE_ALL_ONES) : step0[16]);
  assign timer1_ovf_own = timer1_go && step1[16];
  // Timer 1 loses its flag to the split high half but keeps its overflow tick.
  assign timer1_flag_set = split_mode ? (high0_enable && high0_next[8]) : timer1_ovf_own;

  always @*
  begin
    timer0_overflow_flag_d = timer0_overflow_flag_q;
    timer1_overflow_flag_d = timer1_overflow_flag_q;
    if (timer0_irq_ack)
      timer0_overflow_flag_d = 1'b0;
    if (timer1_irq_ack)
      timer1_overflow_flag_d = 1'b0;
    if (wr_tcs)
    begin
      timer0_overflow_flag_d = sfr_wdata[`TCS_TIMER0_OVERFLOW];
      timer1_overflow_flag_d = sfr_wdata[`TCS_TIMER1_OVERFLOW];
    end
    // Hardware set wins over any clear in the same cycle.
    if (timer0_ovf)
      timer0_overflow_flag_d = 1'b1;
    if (timer1_flag_set)
      timer1_overflow_flag_d = 1'b1;
  end

  ext_irq_detect u_ext_irq0 (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_sync(irq0_pin),
    .type_edge(ext_irq0_type_bit_q),
    .ack(ext_irq0_ack),
    .flag_wr(wr_tcs),
    .flag_wdata(sfr_wdata[`TCS_EXT_IRQ0_FLAG]),
    .flag_q(ext_irq0_flag)
  );

  ext_irq_detect u_ext_irq1 (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_sync(irq1_pin),
    .type_edge(ext_irq1_type_bit_q),
    .ack(ext_irq1_ack),
    .flag_wr(wr_tcs),
    .flag_wdata(sfr_wdata[`TCS_EXT_IRQ1_FLAG]),
    .flag_q(ext_irq1_flag)
  );

  assign timer0_overflow_flag = timer0_overflow_flag_q;
  assign timer1_overflow_flag = timer1_overflow_flag_q;

  always @*
  begin
    case (sfr_addr)
      `ADDR_TIMER_CONTROL_STATUS:
        read_mux = {timer1_overflow_flag_q, timer1_run_bit_q, timer0_overflow_flag_q, timer0_run_bit_q,
          ext_irq1_flag, ext_irq1_type_bit_q, ext_irq0_flag, ext_irq0_type_bit_q};
      `ADDR_TIMER_MODE_CONFIG:
        read_mux = tmc_q;
      `ADDR_TIMER0_COUNT_LOW:
        read_mux = timer0_count_low_q;
      `ADDR_TIMER0_COUNT_HIGH:
        read_mux = timer0_count_high_q;
      `ADDR_TIMER1_COUNT_LOW:
        read_mux = timer1_count_low_q;
      `ADDR_TIMER1_COUNT_HIGH:
        read_mux = timer1_count_high_q;
      default:
        read_mux = `READ_UNMAPPED;
    endcase
  end

  always @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      tmc_q <= `RST_TIMER_MODE_CONFIG;
      timer0_run_bit_q <= 1'b0;
      timer1_run_bit_q <= 1'b0;
      timer0_overflow_flag_q <= 1'b0;
      timer1_overflow_flag_q <= 1'b0;
      ext_irq0_type_bit_q <= 1'b0;
      ext_irq1_type_bit_q <= 1'b0;
      timer0_count_low_q <= `RST_TIMER_COUNT;
      timer0_count_high_q <= `RST_TIMER_COUNT;
      timer1_count_low_q <= `RST_TIMER_COUNT;
      timer1_count_high_q <= `RST_TIMER_COUNT;
      count_prev_q <= 2'b11;
      timer1_overflow_tick_q <= 1'b0;
      sfr_rdata_q <= `RST_TIMER_CONTROL_STATUS;
    end
    else if (clk_en)
    begin
      count_prev_q <= count_pin;
      timer0_overflow_flag_q <= timer0_overflow_flag_d;
      timer1_overflow_flag_q <= timer1_overflow_flag_d;
      timer1_overflow_tick_q <= timer1_ovf_own;
      if (sfr_rd)
        sfr_rdata_q <= read_mux;
      if (wr_tmc)
        tmc_q <= sfr_wdata;
      // Run bits only gate counting; writing them never touches the counts.
      if (wr_tcs)
      begin
        timer0_run_bit_q <= sfr_wdata[`TCS_TIMER0_RUN];
        timer1_run_bit_q <= sfr_wdata[`TCS_TIMER1_RUN];
        ext_irq0_type_bit_q <= sfr_wdata[`TCS_EXT_IRQ0_TYPE];
        ext_irq1_type_bit_q <= sfr_wdata[`TCS_EXT_IRQ1_TYPE];
      end
      // A software write to a count byte takes precedence over that cycle's count.
      if (wr_tl0)
        timer0_count_low_q <= sfr_wdata;
      else if (timer0_enable)
        timer0_count_low_q <= split_mode ? timer0_count_low_q + 8'h01 : step0[7:0];
      if (wr_th0)
        timer0_count_high_q <= sfr_wdata;
      else if (split_mode)
      begin
        if (high0_enable)
          timer0_count_high_q <= high0_next[7:0];
      end
      else if (timer0_enable)
        timer0_count_high_q <= step0[15:8];
      if (wr_tl1)
        timer1_count_low_q <= sfr_wdata;
      else if (timer1_go)
        timer1_count_low_q <= step1[7:0];
      if (wr_th1)
        timer1_count_high_q <= sfr_wdata;
      else if (timer1_go)
        timer1_count_high_q <= step1[15:8];
    end
endmodule

// ---- timer_props.sv ----
// Concurrent checks on the timer block's SFR read port and flag outputs.
// Assumes one clock domain; flags are cleared only by ack pulses or SFR writes.
`timescale 1ns/1ps
module timer_props (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata_q,
  input wire external_irq0_input,
  input wire external_irq1_input,
  input wire timer0_irq_ack,
  input wire timer1_irq_ack,
  input wire ext_irq0_ack,
  input wire ext_irq1_ack,
  input wire timer0_overflow_flag,
  input wire timer1_overflow_flag,
  input wire ext_irq0_flag,
  input wire ext_irq1_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_RDATA_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata_q))
    else $error("read data changed without a read");
  AST_UNMAPPED_ZERO: assert property (sfr_rd && clk_en && (sfr_addr > 8'h8D || sfr_addr < 8'h88) |=> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  AST_TCS_FLAGS: assert property (sfr_rd && clk_en && sfr_addr == 8'h88 |=> sfr_rdata_q[7] == $past(timer1_overflow_flag)
    && sfr_rdata_q[5] == $past(timer0_overflow_flag) && sfr_rdata_q[3] == $past(ext_irq1_flag)
    && sfr_rdata_q[1] == $past(ext_irq0_flag))
    else $error("control register flag bits misplaced");
  AST_EXT0_CAUSE: assert property ($rose(ext_irq0_flag) && !$past(sfr_wr) |-> !$past(external_irq0_input, 3))
    else $error("ext flag 0 set without low pin");
  AST_EXT1_CAUSE: assert property ($rose(ext_irq1_flag) && !$past(sfr_wr) |-> !$past(external_irq1_input, 3))
    else $error("ext flag 1 set without low pin");
  AST_EXT0_STANDS: assert property (ext_irq0_flag && !ext_irq0_ack && !sfr_wr |=> ext_irq0_flag)
    else $error("ext flag 0 dropped without service");
  AST_EXT1_STANDS: assert property (ext_irq1_flag && !ext_irq1_ack && !sfr_wr |=> ext_irq1_flag)
    else $error("ext flag 1 dropped without service");
  AST_TF0_STANDS: assert property (timer0_overflow_flag && !timer0_irq_ack && !sfr_wr |=> timer0_overflow_flag)
    else $error("timer 0 flag dropped without service");
  AST_TF1_STANDS: assert property (timer1_overflow_flag && !timer1_irq_ack && !sfr_wr |=> timer1_overflow_flag)
    else $error("timer 1 flag dropped without service");
endmodule
bind dual_timer_counter timer_props u_timer_props (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q),
  .external_irq0_input(external_irq0_input), .external_irq1_input(external_irq1_input),
  .timer0_irq_ack(timer0_irq_ack), .timer1_irq_ack(timer1_irq_ack), .ext_irq0_ack(ext_irq0_ack),
  .ext_irq1_ack(ext_irq1_ack), .timer0_overflow_flag(timer0_overflow_flag),
  .timer1_overflow_flag(timer1_overflow_flag), .ext_irq0_flag(ext_irq0_flag), .ext_irq1_flag(ext_irq1_flag));

// ---- core_model.sv ----
// Processor core model that issues single-cycle SFR writes and reads.
// Assumes the block answers a read one cycle after the read edge.
`timescale 1ns/1ps
module core_model (
  input wire clock,
  output reg [7:0] sfr_addr,
  output reg [7:0] sfr_wdata,
  output reg sfr_wr,
  output reg sfr_rd,
  input wire [7:0] sfr_rdata_q
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end
  // Idle address and data are inverted so a stale value never looks valid.
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clock);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clock);
    #1 sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge clock);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clock);
    #1 sfr_rd = 1'b0;
    sfr_addr = ~a;
    @(posedge clock);
    #1 d = sfr_rdata_q;
  end
  endtask
endmodule

// ---- dual_timer_counter_tb.sv ----
// Self-checking bench for the dual timer/counter with ext interrupt flags.
// Assumes the core model for SFR access; pins are driven 1 ns after the edge.
`timescale 1ns/1ps
`define CHK(g, e, m) begin compares = compares + 1; if ((g) !== (e)) begin failures = failures + 1; \
  $display("wrong value at %0t: %s", $time, m); end end
module dual_timer_counter_tb;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] xpin = 2'b11;
  reg [1:0] xack = 2'b00;
  reg [1:0] tack = 2'b00;
  reg c0 = 1'b1;
  reg c1 = 1'b1;
  reg ce = 1'b1;
  wire [7:0] sfr_addr, sfr_wdata, sfr_rdata_q;
  wire sfr_wr, sfr_rd, tick;
  wire [1:0] tflag, xflag;
  integer failures = 0, compares = 0, cycles = 0, t, m, n, i;
  reg [7:0] d, h, l;
  reg [16:0] e;
  always #5 clock = ~clock;
  core_model u_core_model (.clock(clock), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q));
  dual_timer_counter u_dual_timer_counter (.clock(clock), .rst_n(rst_n), .clk_en(ce), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q),
    .external_irq0_input(xpin[0]), .external_irq1_input(xpin[1]), .count0_input(c0), .count1_input(c1),
    .timer0_irq_ack(tack[0]), .timer1_irq_ack(tack[1]), .ext_irq0_ack(xack[0]), .ext_irq1_ack(xack[1]),
    .timer0_overflow_flag(tflag[0]), .timer1_overflow_flag(tflag[1]), .ext_irq0_flag(xflag[0]),
    .ext_irq1_flag(xflag[1]), .timer1_overflow_tick_q(tick));
  task results;
  begin
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      results;
    end
  end
  // Steps the timer k times; returns {flag, high, low}.
  function [16:0] nxt(input [1:0] md, input [7:0] hi, input [7:0] lo, input integer k);
    reg f;
    reg [12:0] c;
    integer j;
  begin
    f = 1'b0;
    for (j = 0; j < k; j = j + 1)
    begin
      if (md == 2'h0)
      begin
        c = {hi, lo[4:0]} + 13'h0001;
        hi = c[12:5];
        lo = {lo[7:5], c[4:0]};
        f = f | (c == 13'h0000);
      end
      else if (md == 2'h1)
      begin
        f = f | ({hi, lo} == 16'hFFFF);
        {hi, lo} = {hi, lo} + 16'h0001;
      end
      else
      begin
        f = f | (lo == 8'hFF);
        lo = (lo == 8'hFF) ? hi : lo + 8'h01;
      end
    end
    nxt = {f, hi, lo};
  end
  endfunction
  initial
  begin
    d = $urandom(32'hE525);
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    for (i = 0; i < 7; i = i + 1)
    begin
      u_core_model.rd(8'h88 + i, d);
      `CHK(d, 8'h00, "reset or unmapped value")
    end
    // The mode register goes last: a random split mode lets timer 1 run whatever its run bit says.
    for (i = 1; i < 6; i = i + 1)
    begin
      h = $urandom;
      u_core_model.wr(8'h89 + (i % 5), h);
      u_core_model.rd(8'h89 + (i % 5), d);
      `CHK(d, h, "register readback")
    end
    @(posedge clock);
    #1 xpin = 2'b00;
    for (t = 0; t < 2; t = t + 1)
      for (m = 0; m < 3; m = m + 1)
      begin
        u_core_model.wr(8'h89, 8'h88 | (m << (4 * t)));
        h = (m == 2) ? $urandom : 8'hFF;
        l = (m == 0) ? $urandom : 8'hE0 | $urandom;
        n = $urandom % 30;
        u_core_model.wr(8'h8C + t, h);
        u_core_model.wr(8'h8A + t, l);
        u_core_model.wr(8'h88, 8'h50);
        u_core_model.wr(8'h89, 8'h88 & ~(8'h08 << (4 * t)) | (m << (4 * t)));
        repeat (n) @(posedge clock);
        u_core_model.wr(8'h89, 8'h88 | (m << (4 * t)));
        e = nxt(m, h, l, n + 2);
        `CHK(tflag[t], e[16], "overflow flag")
        tack[t] = 1'b1;
        @(posedge clock);
        #1 tack[t] = 1'b0;
        `CHK(tflag[t], 1'b0, "overflow flag after service")
        u_core_model.wr(8'h88, 8'h50);
        u_core_model.rd(8'h8A + t, d);
        `CHK(m == 0 ? d[4:0] : d, m == 0 ? e[4:0] : e[7:0], "low count")
        u_core_model.rd(8'h8C + t, d);
        `CHK(d, e[15:8], "high count")
      end
    u_core_model.wr(8'h8C, 8'hFE);
    u_core_model.wr(8'h8A, 8'h33);
    u_core_model.wr(8'h8B, 8'h44);
    u_core_model.wr(8'h89, 8'h3B);
    repeat (5) @(posedge clock);
    #1 `CHK(tflag[1], 1'b1, "split high overflow")
    u_core_model.rd(8'h8A, d);
    `CHK(d, 8'h33, "split low half gated")
    u_core_model.rd(8'h8B, d);
    `CHK(d, 8'h44, "timer 1 held in mode 3")
    tack[1] = 1'b1;
    @(posedge clock);
    #1 tack[1] = 1'b0;
    `CHK(tflag[1], 1'b0, "split high flag serviced")
    u_core_model.wr(8'h8D, 8'hFF);
    u_core_model.wr(8'h8B, 8'hFD);
    u_core_model.wr(8'h89, 8'h1B);
    repeat (3) @(posedge clock);
    #1 `CHK(tick, 1'b1, "timer 1 tick while split")
    @(posedge clock);
    #1 `CHK(tick, 1'b0, "timer 1 tick one cycle")
    `CHK(tflag[1], 1'b0, "timer 1 flag owned by split high half")
    u_core_model.wr(8'h89, 8'h55);
    u_core_model.wr(8'h8A, 8'h00);
    u_core_model.wr(8'h8B, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge clock);
      #1 {c1, c0} = 2'b00;
      repeat (3) @(posedge clock);
      #1 {c1, c0} = 2'b11;
      repeat (3) @(posedge clock);
    end
    u_core_model.rd(8'h8A, d);
    `CHK(d, 8'h04, "external count edges")
    u_core_model.rd(8'h8B, d);
    `CHK(d, 8'h04, "timer 1 external count edges")
    u_core_model.wr(8'h8A, 8'h00);
    u_core_model.wr(8'h8C, 8'h00);
    u_core_model.wr(8'h89, 8'h81);
    // Ten frozen edges add nothing; only the two edges of the stopping write count.
    ce = 1'b0;
    repeat (10) @(posedge clock);
    #1 ce = 1'b1;
    u_core_model.wr(8'h89, 8'h88);
    u_core_model.rd(8'h8A, d);
    `CHK(d, 8'h02, "count frozen by clock enable")
    @(posedge clock);
    #1 xpin = 2'b11;
    for (i = 0; i < 2; i = i + 1)
    begin
      repeat (4) @(posedge clock);
      u_core_model.wr(8'h88, 8'h50 | (8'h01 << (2 * i)));
      xpin[i] = 1'b0;
      repeat (5) @(posedge clock);
      #1 `CHK(xflag[i], 1'b1, "edge flag set")
      xack[i] = 1'b1;
      @(posedge clock);
      #1 xack[i] = 1'b0;
      repeat (4) @(posedge clock);
      #1 `CHK(xflag[i], 1'b0, "edge flag stays clear")
      u_core_model.wr(8'h88, 8'h50);
      repeat (3) @(posedge clock);
      #1 `CHK(xflag[i], 1'b1, "level flag set")
      xpin[i] = 1'b1;
    end
    results;
  end
endmodule
